/* core/pecint_pkg.sv */
// package for the pin edge change interrupt block
// assumes a 32-bit axi4-lite register bus, byte addresses, one word per register
package pecint_pkg;
    localparam logic [7:0] PECINT_OFF_PA_RISE  = 8'h00;
    localparam logic [7:0] PECINT_OFF_PA_FALL  = 8'h04;
    localparam logic [7:0] PECINT_OFF_PA_FLAG  = 8'h08;
    localparam logic [7:0] PECINT_OFF_PB_RISE  = 8'h0C;
    localparam logic [7:0] PECINT_OFF_PB_FALL  = 8'h10;
    localparam logic [7:0] PECINT_OFF_PB_FLAG  = 8'h14;
    localparam logic [7:0] PECINT_OFF_CTRL     = 8'h18;
    localparam logic [7:0] PECINT_PA_MASK      = 8'h3B;
    localparam logic [7:0] PECINT_PB_MASK      = 8'hF0;
    localparam logic [7:0] PECINT_PA_LOW_MASK  = 8'h03;
    localparam logic [7:0] PECINT_RST_BYTE     = 8'h00;
    localparam int         PECINT_CTRL_MEN_BIT = 0;
    localparam int         PECINT_CTRL_CMB_BIT = 1;
    localparam int         PECINT_CTRL_USB_BIT = 2;
    localparam logic [1:0] PECINT_RESP_OKAY    = 2'b00;
    localparam logic [1:0] PECINT_RESP_SLVERR  = 2'b10;
endpackage

/* core/pecint_edge_if.sv */
// carries pin samples, enables and detected edges between the top and the detector
// assumes one clock domain, driven by the top module
`timescale 1ns/1ps
interface pecint_edge_if;
    logic [7:0] pins;
    logic [7:0] rise_en;
    logic [7:0] fall_en;
    logic [7:0] hit;
    modport top (output pins, output rise_en, output fall_en, input hit);
    modport det (input pins, input rise_en, input fall_en, output hit);
endinterface

/* core/pecint_edge_det.sv */
// per-port synchroniser and edge detector for eight pins
// assumes pins are asynchronous; enables come from the register file
`timescale 1ns/1ps
module pecint_edge_det
    import pecint_pkg::*;
(
    input  wire logic   aclk,
    input  wire logic   aresetn,
    pecint_edge_if.det  e
);
    logic [7:0] sync1_r;
    logic [7:0] sync2_r;
    logic [7:0] prev_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= PECINT_RST_BYTE;
            sync2_r <= PECINT_RST_BYTE;
            prev_r  <= PECINT_RST_BYTE;
        end else begin
            sync1_r <= e.pins;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    // edge is a compare of the synced level with the previous cycle
    assign e.hit = (e.rise_en & sync2_r & ~prev_r)
                 | (e.fall_en & ~sync2_r & prev_r);
endmodule // pecint_edge_det

/* core/pecint_top.sv */
// pin edge change interrupt block: two ports, axi4-lite registers
// assumes pins asynchronous to aclk; wake and irq go to the core's power and interrupt logic
// Notes on behaviour
// - wake request from sleep only while master enable is set
// - flags update during sleep, before the core resumes executing
// - port a rising enables live at bits 5-3 and 1-0
// - port a falling enables live at bits 5-3 and 1-0
// - port b rising enables live at bits 7-4
// - port b falling enables live at bits 7-4
// - port a flag sets on an enabled rising or falling edge
// - port b flag sets on an enabled rising or falling edge
// - flags stay set until software writes zero
// - unused bit positions read zero and ignore writes
// - port a low pins detect only while usb function is off
// - any enabled edge sets pin flag and combined flag
// - combined flag is the or of all pin flags
// - detection continues with master enable clear; only interrupt and wake request suppressed
// - an edge during a flag write leaves that flag set
`timescale 1ns/1ps
module pecint_top
    import pecint_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  porta_pin,
    input  wire logic [7:0]  portb_pin,
    input  wire logic        usb_enabled,
    output logic             change_combined_flag,
    output logic             change_irq,
    output logic             wake_req
);
    logic [7:0] porta_rising_enable_r;
    logic [7:0] porta_falling_enable_r;
    logic [7:0] porta_change_flags_r;
    logic [7:0] portb_rising_enable_r;
    logic [7:0] portb_falling_enable_r;
    logic [7:0] portb_change_flags_r;
    logic       change_master_enable_r;
    logic       usb_s1_r;
    logic       usb_s2_r;

    logic [7:0] aw_addr_r;
    logic       aw_full_r;
    logic [7:0] w_data_r;
    logic       w_lane0_r;
    logic       w_full_r;
    logic [1:0] bresp_r;
    logic       bvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic       rvalid_r;

    logic       wr_go;
    logic       wr_hit;
    logic [7:0] pa_hit;
    logic [7:0] pb_hit;
    logic [7:0] pa_det_en;
    logic [7:0] rd_val;
    logic       rd_hit;
    logic       wr_pa_rise;
    logic       wr_pa_fall;
    logic       wr_pa_flag;
    logic       wr_pb_rise;
    logic       wr_pb_fall;
    logic       wr_pb_flag;
    logic       wr_ctrl;
    logic [7:0] porta_change_flags_nxt;
    logic [7:0] portb_change_flags_nxt;
    logic [7:0] ctrl_rd;

    pecint_edge_if pa_if ();
    pecint_edge_if pb_if ();

    // usb enable is from another block's domain
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            usb_s1_r <= 1'b0;
            usb_s2_r <= 1'b0;
        end else begin
            usb_s1_r <= usb_enabled;
            usb_s2_r <= usb_s1_r;
        end
    end

    // low port a pins lose their digital buffer while usb owns them
    assign pa_det_en = usb_s2_r ? ~PECINT_PA_LOW_MASK : 8'hFF;

    assign pa_if.pins    = porta_pin;
    assign pa_if.rise_en = porta_rising_enable_r & pa_det_en;
    assign pa_if.fall_en = porta_falling_enable_r & pa_det_en;
    assign pa_hit        = pa_if.hit & PECINT_PA_MASK;
    assign pb_if.pins    = portb_pin;
    assign pb_if.rise_en = portb_rising_enable_r;
    assign pb_if.fall_en = portb_falling_enable_r;
    assign pb_hit        = pb_if.hit & PECINT_PB_MASK;

    pecint_edge_det u_det_a (
        .aclk    (aclk),
        .aresetn (aresetn),
        .e       (pa_if.det)
    );

    pecint_edge_det u_det_b (
        .aclk    (aclk),
        .aresetn (aresetn),
        .e       (pb_if.det)
    );

    // write channel: address and data caught independently, either order
    assign s_axi_awready = !aw_full_r && !bvalid_r;
    assign s_axi_wready  = !w_full_r && !bvalid_r;
    assign wr_go         = aw_full_r && w_full_r && !bvalid_r;
    assign wr_hit        = wr_go && w_lane0_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_r <= 1'b1;
        end else if (wr_go) begin
            aw_full_r <= 1'b0;
        end
    end

    // address is captured only on acceptance, so it holds until the write retires
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_r <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_r <= s_axi_awaddr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_r <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_r <= 1'b1;
        end else if (wr_go) begin
            w_full_r <= 1'b0;
        end
    end

    // only the low byte lane carries a register; upper lanes are dropped on purpose
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_data_r  <= 8'h00;
            w_lane0_r <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_data_r  <= s_axi_wdata[7:0];
            w_lane0_r <= s_axi_wstrb[0];
        end
    end

    // one strobe per register keeps the update blocks free of address compares
    assign wr_pa_rise = wr_hit && (aw_addr_r == PECINT_OFF_PA_RISE);
    assign wr_pa_fall = wr_hit && (aw_addr_r == PECINT_OFF_PA_FALL);
    assign wr_pa_flag = wr_hit && (aw_addr_r == PECINT_OFF_PA_FLAG);
    assign wr_pb_rise = wr_hit && (aw_addr_r == PECINT_OFF_PB_RISE);
    assign wr_pb_fall = wr_hit && (aw_addr_r == PECINT_OFF_PB_FALL);
    assign wr_pb_flag = wr_hit && (aw_addr_r == PECINT_OFF_PB_FLAG);
    assign wr_ctrl    = wr_hit && (aw_addr_r == PECINT_OFF_CTRL);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // unmapped addresses answer slverr and change nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bresp_r <= PECINT_RESP_OKAY;
        end else if (wr_go) begin
            case (aw_addr_r)
                PECINT_OFF_PA_RISE, PECINT_OFF_PA_FALL, PECINT_OFF_PA_FLAG,
                PECINT_OFF_PB_RISE, PECINT_OFF_PB_FALL, PECINT_OFF_PB_FLAG,
                PECINT_OFF_CTRL: begin
                    bresp_r <= PECINT_RESP_OKAY;
                end
                default: begin
                    bresp_r <= PECINT_RESP_SLVERR;
                end
            endcase
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;

    // enable registers; unimplemented bits masked off on write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            porta_rising_enable_r <= PECINT_RST_BYTE;
        end else if (wr_pa_rise) begin
            porta_rising_enable_r <= w_data_r & PECINT_PA_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            porta_falling_enable_r <= PECINT_RST_BYTE;
        end else if (wr_pa_fall) begin
            porta_falling_enable_r <= w_data_r & PECINT_PA_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            portb_rising_enable_r <= PECINT_RST_BYTE;
        end else if (wr_pb_rise) begin
            portb_rising_enable_r <= w_data_r & PECINT_PB_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            portb_falling_enable_r <= PECINT_RST_BYTE;
        end else if (wr_pb_fall) begin
            portb_falling_enable_r <= w_data_r & PECINT_PB_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            change_master_enable_r <= 1'b0;
        end else if (wr_ctrl) begin
            change_master_enable_r <= w_data_r[PECINT_CTRL_MEN_BIT];
        end
    end

    // flags: a same-cycle edge wins over a software write of zero
    always_comb begin
        porta_change_flags_nxt = porta_change_flags_r;
        if (wr_pa_flag) begin
            porta_change_flags_nxt = w_data_r & PECINT_PA_MASK;
        end
        porta_change_flags_nxt = porta_change_flags_nxt | pa_hit;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            porta_change_flags_r <= PECINT_RST_BYTE;
        end else begin
            porta_change_flags_r <= porta_change_flags_nxt;
        end
    end

    always_comb begin
        portb_change_flags_nxt = portb_change_flags_r;
        if (wr_pb_flag) begin
            portb_change_flags_nxt = w_data_r & PECINT_PB_MASK;
        end
        portb_change_flags_nxt = portb_change_flags_nxt | pb_hit;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            portb_change_flags_r <= PECINT_RST_BYTE;
        end else begin
            portb_change_flags_r <= portb_change_flags_nxt;
        end
    end

    // combined flag is an or of held flags, so it clears only with them
    assign change_combined_flag = |{porta_change_flags_r, portb_change_flags_r};
    // detection needs no core clock gating here; flags settle before wake is seen
    assign change_irq = change_combined_flag && change_master_enable_r;
    assign wake_req   = change_combined_flag && change_master_enable_r;

    // status view: master enable, combined flag and the synced usb level
    always_comb begin
        ctrl_rd                      = 8'h00;
        ctrl_rd[PECINT_CTRL_MEN_BIT] = change_master_enable_r;
        ctrl_rd[PECINT_CTRL_CMB_BIT] = change_combined_flag;
        ctrl_rd[PECINT_CTRL_USB_BIT] = usb_s2_r;
    end

    // read channel: one outstanding read, answered the cycle after arvalid is taken
    assign s_axi_arready = !rvalid_r;

    always_comb begin
        rd_val = 8'h00;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            PECINT_OFF_PA_RISE: rd_val = porta_rising_enable_r;
            PECINT_OFF_PA_FALL: rd_val = porta_falling_enable_r;
            PECINT_OFF_PA_FLAG: rd_val = porta_change_flags_r;
            PECINT_OFF_PB_RISE: rd_val = portb_rising_enable_r;
            PECINT_OFF_PB_FALL: rd_val = portb_falling_enable_r;
            PECINT_OFF_PB_FLAG: rd_val = portb_change_flags_r;
            PECINT_OFF_CTRL:    rd_val = ctrl_rd;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // payload loads only on acceptance, so it holds while rvalid waits for rready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_r <= 32'h0000_0000;
            rresp_r <= PECINT_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rdata_r <= {24'h00_0000, rd_val};
            rresp_r <= rd_hit ? PECINT_RESP_OKAY : PECINT_RESP_SLVERR;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata  = rdata_r;
    assign s_axi_rresp  = rresp_r;
endmodule // pecint_top

/* sim/pecint_pins.sv */
// model of the port input pins driven into the change block
// assumes the bench calls drive; levels move just after a rising edge
`timescale 1ns/1ps
module pecint_pins (
    input  wire logic  aclk,
    output logic [7:0] porta_pin,
    output logic [7:0] portb_pin,
    output logic       usb_enabled
);
    initial begin
        porta_pin = 8'h00;
        portb_pin = 8'h00;
        usb_enabled = 1'h0;
    end
    // levels are held until the next call, never a pulse shorter than the synchroniser
    task drive(input logic [7:0] a, input logic [7:0] b, input logic u);
        @(posedge aclk);
        porta_pin <= a;
        portb_pin <= b;
        usb_enabled <= u;
    endtask
endmodule // pecint_pins

/* sim/pecint_top_sva.sv */
// checker for the pin edge change block
// assumes it is bound to pecint_top and sees only its ports
`timescale 1ns/1ps
module pecint_top_sva (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  porta_pin,
    input wire logic [7:0]  portb_pin,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        change_combined_flag,
    input wire logic        change_irq,
    input wire logic        wake_req
);
    logic [15:0] pin_q;
    logic [3:0]  quiet;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // cycles since any pin moved; saturates so long idle stretches stay cheap
    always_ff @(posedge aclk) begin
        pin_q <= {porta_pin, portb_pin};
        if (!aresetn) quiet <= 4'hF;
        else if (pin_q != {porta_pin, portb_pin}) quiet <= 4'h0;
        else if (quiet != 4'hF) quiet <= quiet + 4'h1;
    end
    wake_same_a: assert property (wake_req == change_irq)
        else $error("wake request differs from irq");
    irq_gated_a: assert property (change_irq |-> change_combined_flag)
        else $error("irq without a flag");
    flag_kept_a: assert property ($fell(change_combined_flag) |-> $rose(s_axi_bvalid))
        else $error("flag cleared without a write");
    flag_delay_a: assert property ($rose(change_combined_flag) |-> quiet == 4'h2)
        else $error("flag rose at the wrong distance from a pin change");
    rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    ar_idle_a: assert property (!s_axi_rvalid |-> s_axi_arready)
        else $error("read address refused while idle");
    wake_cause_a: assert property ($rose(wake_req) |->
        $rose(change_combined_flag) || $rose(s_axi_bvalid))
        else $error("wake request without a new flag or a register write");
endmodule // pecint_top_sva

bind pecint_top pecint_top_sva u_sva (.aclk, .aresetn, .porta_pin, .portb_pin,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
    .change_combined_flag, .change_irq, .wake_req);

/* sim/pecint_top_tb.sv */
// bench for the pin edge change block: register tasks and pin scenarios
// assumes pecint_pins drives the pins and the checker is bound
`timescale 1ns/1ps
module pecint_top_tb;
    import pecint_pkg::*;
    logic        aclk;
    logic        aresetn = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, porta_pin, portb_pin, last_rd;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, usb_enabled;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        change_combined_flag, change_irq, wake_req;
    int          bad_count = 0, samples_checked = 0, i;
    logic [7:0]  offs [4] = '{PECINT_OFF_PA_RISE, PECINT_OFF_PA_FALL,
                              PECINT_OFF_PB_RISE, PECINT_OFF_PB_FALL};
    logic [7:0]  msks [4] = '{PECINT_PA_MASK, PECINT_PA_MASK, PECINT_PB_MASK, PECINT_PB_MASK};

    pecint_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .porta_pin, .portb_pin,
        .usb_enabled, .change_combined_flag, .change_irq, .wake_req);
    pecint_pins u_pins (.aclk, .porta_pin, .portb_pin, .usb_enabled);

    initial begin
        aclk = 1'h0;
        forever #20 aclk = ~aclk;
    end

    task give_verdict();
        if (bad_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input logic [33:0] got, input logic [33:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        n = 0;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            n++;
        end while (!s_axi_bvalid && n < 40);
        s_axi_bready <= 1'h0;
        if (n >= 40) begin
            bad_count++;
            give_verdict();
        end else begin
            chk({32'h00000000, s_axi_bresp}, {32'h00000000, er});
        end
    endtask

    task rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        n = 0;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            n++;
        end while (!s_axi_rvalid && n < 40);
        s_axi_rready <= 1'h0;
        if (n >= 40) begin
            bad_count++;
            give_verdict();
        end else begin
            last_rd = s_axi_rdata[7:0];
            chk({s_axi_rresp, s_axi_rdata}, {er, 24'h000000, ed});
        end
    endtask

    // the two-flop synchroniser and the flag register need three edges; six leaves margin before the flags are read
    task pin(input logic [7:0] a, input logic [7:0] b, input logic u);
        u_pins.drive(a, b, u);
        repeat (6) @(posedge aclk);
    endtask

    task outs(input logic [2:0] e);
        chk({31'h00000000, change_combined_flag, change_irq, wake_req}, {31'h00000000, e});
    endtask

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        for (i = 0; i < 7; i++) rd(8'(i * 4), PECINT_RST_BYTE, PECINT_RESP_OKAY);
        rd(8'h1C, 8'h00, PECINT_RESP_SLVERR);
        wr(8'h1C, 8'hFF, PECINT_RESP_SLVERR);
        for (i = 0; i < 4; i++) begin
            wr(offs[i], 8'hFF, PECINT_RESP_OKAY);
            rd(offs[i], msks[i], PECINT_RESP_OKAY);
        end
        // a write without the low byte lane must leave the register alone
        s_axi_wstrb <= 4'hE;
        wr(PECINT_OFF_PA_RISE, 8'h00, PECINT_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(PECINT_OFF_PA_RISE, PECINT_PA_MASK, PECINT_RESP_OKAY);
        wr(PECINT_OFF_CTRL, 8'h01, PECINT_RESP_OKAY);
        pin(8'hFF, 8'h00, 1'h0);
        rd(PECINT_OFF_PA_FLAG, 8'h3B, PECINT_RESP_OKAY);
        outs(3'h7);
        rd(PECINT_OFF_CTRL, 8'h03, PECINT_RESP_OKAY);
        wr(PECINT_OFF_PB_RISE, 8'h00, PECINT_RESP_OKAY);
        pin(8'hFF, 8'hF0, 1'h0);
        rd(PECINT_OFF_PB_FLAG, 8'h00, PECINT_RESP_OKAY);
        pin(8'hFF, 8'h00, 1'h0);
        rd(PECINT_OFF_PB_FLAG, 8'hF0, PECINT_RESP_OKAY);
        rd(PECINT_OFF_PA_FLAG, 8'h3B, PECINT_RESP_OKAY);
        wr(PECINT_OFF_PA_FLAG, last_rd & (last_rd ^ 8'hFF), PECINT_RESP_OKAY);
        rd(PECINT_OFF_PA_FLAG, 8'h00, PECINT_RESP_OKAY);
        outs(3'h7);
        wr(PECINT_OFF_PB_FLAG, 8'h00, PECINT_RESP_OKAY);
        outs(3'h0);
        wr(PECINT_OFF_CTRL, 8'h00, PECINT_RESP_OKAY);
        pin(8'h00, 8'h00, 1'h0);
        rd(PECINT_OFF_PA_FLAG, 8'h3B, PECINT_RESP_OKAY);
        outs(3'h4);
        rd(PECINT_OFF_CTRL, 8'h02, PECINT_RESP_OKAY);
        wr(PECINT_OFF_PA_FLAG, 8'h00, PECINT_RESP_OKAY);
        pin(8'h00, 8'h00, 1'h1);
        rd(PECINT_OFF_CTRL, 8'h04, PECINT_RESP_OKAY);
        pin(8'h03, 8'h00, 1'h1);
        rd(PECINT_OFF_PA_FLAG, 8'h00, PECINT_RESP_OKAY);
        pin(8'h03, 8'h00, 1'h0);
        pin(8'h00, 8'h00, 1'h0);
        rd(PECINT_OFF_PA_FLAG, 8'h03, PECINT_RESP_OKAY);
        wr(PECINT_OFF_PA_FLAG, 8'h00, PECINT_RESP_OKAY);
        // the pin edge lands on the same clock as the flag write below
        u_pins.drive(8'h03, 8'h00, 1'h0);
        wr(PECINT_OFF_PA_FLAG, 8'h00, PECINT_RESP_OKAY);
        rd(PECINT_OFF_PA_FLAG, 8'h03, PECINT_RESP_OKAY);
        give_verdict();
    end
endmodule // pecint_top_tb
